/* tci_pkg.sv */
package tci_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial word layout
  localparam int unsigned SHIFT_W = 18;
  localparam int unsigned DATA_W = 14;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned NUM_REGS = 16;
  localparam int unsigned DATA_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [3:0] REG_PLL_MODE_CONFIG = 4'h0;
  localparam logic [3:0] REG_LOCK_OUTPUT_TYPE_CONFIG = 4'h1;
  localparam logic [3:0] REG_SYNTH_RESERVED_CONFIG = 4'h2;
  localparam logic [3:0] REG_INTEGER_DIVIDER = 4'h3;
  localparam logic [3:0] REG_FRACTIONAL_DIVIDER_UPPER = 4'h4;
  localparam logic [3:0] REG_LOCK_OUTPUT_REFDIV_CONFIG = 4'h5;
  localparam logic [3:0] REG_CONFIG_WORD_6 = 4'h6;
  localparam logic [3:0] REG_CONFIG_WORD_7 = 4'h7;
  localparam logic [3:0] REG_CONFIG_WORD_8 = 4'h8;
  localparam logic [3:0] REG_CONFIG_WORD_9 = 4'h9;
  localparam logic [3:0] REG_CONFIG_WORD_10 = 4'hA;
  localparam logic [3:0] REG_CONFIG_WORD_11 = 4'hB;
  localparam logic [3:0] REG_CONFIG_WORD_12 = 4'hC;
  localparam logic [3:0] REG_CONFIG_WORD_13 = 4'hD;
  localparam logic [3:0] REG_REFERENCE_CLOCK_OUTPUT_CONFIG = 4'hE;
  localparam logic [3:0] REG_CONFIG_WORD_15 = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside the 14 data bits
  localparam int unsigned FRAC_MODE_BIT = 10;
  localparam int unsigned LOCK_CMOS_BIT = 12;
  localparam int unsigned INT_DIV_LSB = 0;
  localparam int unsigned FRAC_LOW_LSB = 8;
  localparam int unsigned LOCK_PULLUP_BIT = 9;
  localparam int unsigned LOCK_EN_BIT = 5;
  localparam int unsigned REF_DIV2_BIT = 2;
  localparam int unsigned CLKOUT_DIV2_BIT = 10;
  localparam int unsigned CLKOUT_EN_BIT = 9;

  ////////////////////////////////////////////////////////////////////////////
  // reset values of decoded fields (recommended settings)
  localparam logic RST_FRAC_MODE = 1'b1;
  localparam logic RST_LOCK_CMOS = 1'b1;
  localparam logic [7:0] RST_INT_DIV = 8'h79;
  localparam logic [5:0] RST_FRAC_LOW = 6'h00;
  localparam logic [13:0] RST_FRAC_HIGH = 14'h3666;
  localparam logic RST_LOCK_PULLUP = 1'b0;
  localparam logic RST_LOCK_EN = 1'b1;
  localparam logic RST_REF_DIV2 = 1'b1;
  localparam logic RST_CLKOUT_DIV2 = 1'b0;
  localparam logic RST_CLKOUT_EN = 1'b1;

  // smallest legal integer divisor
  localparam logic [7:0] INT_DIV_MIN = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } tci_serial_t;

  typedef struct packed {
    logic frac_mode;
    logic ref_div2;
    logic [7:0] int_div;
    logic [19:0] frac_div;
  } tci_synth_cfg_t;

endpackage

/* tci_reg_bank.sv */
`timescale 1ns/1ps
module tci_reg_bank
  import tci_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o
);

  // no reset: power-on contents are undefined until software loads them
  logic [DATA_W-1:0] mem_r [NUM_REGS];

  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule

/* tci_config_port.sv */
// How it works
// - sixteen registers, each loaded by 18-bit word
// - upper 14 bits data, low 4 address
// - shift data on clock rise, select low
// - select rising latches word into addressed register
// - keep last 18 bits, no count check
// - reg14 bit10 divides reference output by two
// - reg14 bit9 enables reference clock output
// - lock indicator high locked, low unlocked
// - reg5 bit5 enables lock output, else floating
// - reg1 bit12 selects push-pull or open-drain
// - reg5 bit9 pull-up in open-drain mode
// - reg0 bit10 selects fractional or integer mode
// - reg3 low byte integer divider, 64..255
// - reg3 bits13:8 low six fraction bits
// - reg4 holds upper fourteen fraction bits
// - reg5 bit2 sets synthesizer reference divider
`timescale 1ns/1ps
module tci_config_port
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial configuration pins
  input wire tci_pkg::tci_serial_t serial_i,
  // synthesizer status and reference
  input wire logic pll_locked_i,
  input wire logic ref_clk_i,
  // synthesizer settings
  output tci_pkg::tci_synth_cfg_t synth_cfg_o,
  output logic int_div_valid_o,
  // lock indicator pin
  output logic lock_indicator_o,
  output logic lock_indicator_oe_o,
  output logic lock_pullup_en_o,
  // reference clock output pin
  output logic reference_clock_output_o
);

  import tci_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // serial edge detection
  logic sclk_prev_r;
  logic cs_n_prev_r;
  logic sclk_rise;
  logic cs_rise;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sclk_prev_r <= 1'b0;
      cs_n_prev_r <= 1'b1;
    end
    else
    begin
      sclk_prev_r <= serial_i.sclk;
      cs_n_prev_r <= serial_i.cs_n;
    end
  end

  // clock edges seen while select is high never reach the shifter
  assign sclk_rise = serial_i.sclk && !sclk_prev_r && !serial_i.cs_n;
  assign cs_rise = serial_i.cs_n && !cs_n_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // shift register
  logic [SHIFT_W-1:0] shift_r;
  // older bits fall off the top; a short frame simply leaves stale bits
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      shift_r <= '0;
    end
    else if (sclk_rise)
    begin
      shift_r <= {shift_r[SHIFT_W-2:0], serial_i.din};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch on select rising
  logic wr_en_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_en_r <= 1'b0;
    end
    else
    begin
      wr_en_r <= cs_rise;
    end
  end

  // word split: data on top, address in the low nibble; only read under wr_en_r
  always_ff @(posedge clk_sys_i)
  begin
    if (cs_rise)
    begin
      wr_addr_r <= shift_r[ADDR_W-1:0];
      wr_data_r <= shift_r[SHIFT_W-1:DATA_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank and decode pipeline
  logic rd_req_r;
  logic rd_vld_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [ADDR_W-1:0] dec_addr_r;
  logic [DATA_W-1:0] rd_data;
  // write first, read one cycle later so the bank needs no bypass
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_req_r <= 1'b0;
      rd_vld_r <= 1'b0;
      rd_addr_r <= '0;
      dec_addr_r <= '0;
    end
    else
    begin
      rd_req_r <= wr_en_r;
      rd_vld_r <= rd_req_r;
      if (wr_en_r)
      begin
        rd_addr_r <= wr_addr_r;
      end
      dec_addr_r <= rd_addr_r;
    end
  end

  tci_reg_bank u_bank (
    .clk_sys_i (clk_sys_i),
    .wr_en_i (wr_en_r),
    .wr_addr_i (wr_addr_r),
    .wr_data_i (wr_data_r),
    .rd_addr_i (rd_addr_r),
    .rd_data_o (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoded fields; the bank itself is never visible at the pins
  logic frac_mode_r;
  logic lock_cmos_r;
  logic [7:0] int_div_r;
  logic [5:0] frac_low_r;
  logic [13:0] frac_high_r;
  logic lock_pullup_r;
  logic lock_en_r;
  logic ref_div2_r;
  logic clkout_div2_r;
  logic clkout_en_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      frac_mode_r <= RST_FRAC_MODE;
      lock_cmos_r <= RST_LOCK_CMOS;
      int_div_r <= RST_INT_DIV;
      frac_low_r <= RST_FRAC_LOW;
      frac_high_r <= RST_FRAC_HIGH;
      lock_pullup_r <= RST_LOCK_PULLUP;
      lock_en_r <= RST_LOCK_EN;
      ref_div2_r <= RST_REF_DIV2;
      clkout_div2_r <= RST_CLKOUT_DIV2;
      clkout_en_r <= RST_CLKOUT_EN;
    end
    else if (rd_vld_r)
    begin
      case (dec_addr_r)
        REG_PLL_MODE_CONFIG:
        begin
          frac_mode_r <= rd_data[FRAC_MODE_BIT];
        end
        REG_LOCK_OUTPUT_TYPE_CONFIG:
        begin
          lock_cmos_r <= rd_data[LOCK_CMOS_BIT];
        end
        REG_INTEGER_DIVIDER:
        begin
          int_div_r <= rd_data[INT_DIV_LSB +: 8];
          frac_low_r <= rd_data[FRAC_LOW_LSB +: 6];
        end
        REG_FRACTIONAL_DIVIDER_UPPER:
        begin
          frac_high_r <= rd_data;
        end
        REG_LOCK_OUTPUT_REFDIV_CONFIG:
        begin
          lock_pullup_r <= rd_data[LOCK_PULLUP_BIT];
          lock_en_r <= rd_data[LOCK_EN_BIT];
          ref_div2_r <= rd_data[REF_DIV2_BIT];
        end
        REG_REFERENCE_CLOCK_OUTPUT_CONFIG:
        begin
          clkout_div2_r <= rd_data[CLKOUT_DIV2_BIT];
          clkout_en_r <= rd_data[CLKOUT_EN_BIT];
        end
        default:
        begin
          // analog-only words: stored in the bank, nothing to decode here
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synthesizer outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      synth_cfg_o <= '{RST_FRAC_MODE, RST_REF_DIV2, RST_INT_DIV, {RST_FRAC_HIGH, RST_FRAC_LOW}};
      int_div_valid_o <= 1'b1;
    end
    else
    begin
      synth_cfg_o.frac_mode <= frac_mode_r;
      synth_cfg_o.ref_div2 <= ref_div2_r;
      synth_cfg_o.int_div <= int_div_r;
      synth_cfg_o.frac_div <= {frac_high_r, frac_low_r};
      // out-of-range divisors are flagged, not clamped
      int_div_valid_o <= (int_div_r >= INT_DIV_MIN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock indicator driver
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      lock_indicator_o <= 1'b0;
      lock_indicator_oe_o <= 1'b0;
      lock_pullup_en_o <= 1'b0;
    end
    else if (!lock_en_r)
    begin
      lock_indicator_o <= 1'b0;
      lock_indicator_oe_o <= 1'b0;
      lock_pullup_en_o <= 1'b0;
    end
    else if (lock_cmos_r)
    begin
      lock_indicator_o <= pll_locked_i;
      lock_indicator_oe_o <= 1'b1;
      lock_pullup_en_o <= 1'b0;
    end
    else
    begin
      // open drain only ever pulls low; high comes from the pull-up
      lock_indicator_o <= 1'b0;
      lock_indicator_oe_o <= !pll_locked_i;
      lock_pullup_en_o <= lock_pullup_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference clock output divider and buffer
  logic ref_prev_r;
  logic ref_half_r;
  // divider runs independently of the synthesizer reference divider
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ref_prev_r <= 1'b0;
      ref_half_r <= 1'b0;
    end
    else
    begin
      ref_prev_r <= ref_clk_i;
      if (ref_clk_i && !ref_prev_r)
      begin
        ref_half_r <= !ref_half_r;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      reference_clock_output_o <= 1'b0;
    end
    else if (!clkout_en_r)
    begin
      reference_clock_output_o <= 1'b0;
    end
    else
    begin
      reference_clock_output_o <= clkout_div2_r ? ref_half_r : ref_clk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  shift_in_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    sclk_rise |=> (shift_r[0] == $past(serial_i.din))
      && (shift_r[SHIFT_W-1:1] == $past(shift_r[SHIFT_W-2:0])))
    else $error("shift register missed a serial clock edge");
  shift_idle_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    serial_i.cs_n |=> $stable(shift_r))
    else $error("shift register moved while select high");
  latch_word_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    cs_rise |=> wr_en_r && (wr_addr_r == $past(shift_r[ADDR_W-1:0]))
      && (wr_data_r == $past(shift_r[SHIFT_W-1:DATA_LSB])))
    else $error("select rise did not latch the shifted word");
  latch_once_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_en_r |=> !wr_en_r)
    else $error("one select rise wrote more than once");
  mode_update_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_en_r && wr_addr_r == REG_PLL_MODE_CONFIG) |-> ##4
      synth_cfg_o.frac_mode == $past(wr_data_r[FRAC_MODE_BIT], 4))
    else $error("mode bit not applied four cycles after write");
  int_range_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_en_r && wr_addr_r == REG_INTEGER_DIVIDER) |-> ##4
      (int_div_valid_o == ($past(wr_data_r[7:0], 4) >= INT_DIV_MIN))
      && (synth_cfg_o.int_div == $past(wr_data_r[7:0], 4)))
    else $error("integer divider or range flag wrong");
  frac_split_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_en_r && wr_addr_r == REG_FRACTIONAL_DIVIDER_UPPER) |-> ##4
      synth_cfg_o.frac_div[19:6] == $past(wr_data_r, 4))
    else $error("upper fraction bits not applied");
  lock_off_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !lock_en_r |=> !lock_indicator_oe_o && !lock_pullup_en_o)
    else $error("lock pin driven while disabled");
  lock_cmos_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (lock_en_r && lock_cmos_r) |=> lock_indicator_oe_o
      && (lock_indicator_o == $past(pll_locked_i)))
    else $error("push-pull lock pin does not follow lock state");
  lock_drain_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (lock_en_r && !lock_cmos_r) |=> !lock_indicator_o
      && (lock_indicator_oe_o == !$past(pll_locked_i)))
    else $error("open-drain lock pin drove high or wrong level");
  clkout_off_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !clkout_en_r |=> !reference_clock_output_o)
    else $error("reference output active while disabled");
  // the output trails the toggle flop by one clock, hence the extra cycle
  clkout_half_a: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (clkout_en_r && clkout_div2_r && !(ref_clk_i && !ref_prev_r)) ##1
      (clkout_en_r && clkout_div2_r) |=> $stable(reference_clock_output_o))
    else $error("halved reference output changed without a source edge");
endmodule

/* tci_host_model.sv */
`timescale 1ns/1ps
module tci_host_model
  import tci_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // serial pins toward the device
  output tci_pkg::tci_serial_t serial_o
);
  ////////////////////////////////////////////////////////////////////////////
  // idle: select high, clock parked low
  initial serial_o = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

  // msb first, whole word framed by select low; short words allowed
  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk_sys_i);
      serial_o <= '{cs_n: 1'b0, sclk: 1'b0, din: w[i]};
      @(posedge clk_sys_i);
      serial_o.sclk <= 1'b1;
    end
    @(posedge clk_sys_i);
    serial_o.sclk <= 1'b0;
    @(posedge clk_sys_i);
    serial_o.cs_n <= 1'b1;
    // released data line must not keep showing the last bit
    serial_o.din <= ~serial_o.din;
    repeat (10) @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock pulses with select high, data held at one
  task automatic stray(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      serial_o <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b1};
      @(posedge clk_sys_i);
      serial_o.sclk <= 1'b0;
    end
  endtask
endmodule

/* test_three_wire_config_interface.sv */
`timescale 1ns/1ps
module test_three_wire_config_interface;
  import tci_pkg::*;
  logic clk_sys_i;
  logic rst_i;
  logic pll_locked_i;
  logic ref_clk_i;
  logic [2:0] ref_cnt;
  tci_serial_t serial;
  tci_synth_cfg_t cfg;
  tci_synth_cfg_t exp_cfg;
  logic div_ok;
  logic lock_o;
  logic lock_oe;
  logic lock_pu;
  logic ref_out;
  logic [13:0] r1;
  logic [13:0] r5;
  logic [13:0] r14;
  logic [17:0] sr_m;
  int n_errors;
  int n_checks;
  // recommended settings, one per address
  logic [13:0] rec [16] = '{14'h1740, 14'h119A, 14'h1003, 14'h0079, 14'h3666, 14'h00A4,
    14'h0060, 14'h1022, 14'h2021, 14'h03B5, 14'h1DA4, 14'h007F, 14'h0140, 14'h0E92,
    14'h033B, 14'h0145};
  logic [7:0] div_tbl [3] = '{8'h3F, 8'h40, 8'hFF};
  logic [13:0] lk1 [4] = '{14'h119A, 14'h019A, 14'h019A, 14'h019A};
  logic [13:0] lk5 [4] = '{14'h00A4, 14'h02A4, 14'h00A4, 14'h0284};
  logic [13:0] ck_tbl [3] = '{14'h033B, 14'h073B, 14'h013B};

  tci_host_model host (.clk_sys_i(clk_sys_i), .serial_o(serial));
  tci_config_port DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .serial_i(serial),
    .pll_locked_i(pll_locked_i), .ref_clk_i(ref_clk_i), .synth_cfg_o(cfg),
    .int_div_valid_o(div_ok), .lock_indicator_o(lock_o), .lock_indicator_oe_o(lock_oe),
    .lock_pullup_en_o(lock_pu), .reference_clock_output_o(ref_out));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // reference oscillator, eight system clocks a period
  always @(posedge clk_sys_i)
  begin
    ref_cnt <= ref_cnt + 3'h1;
    ref_clk_i <= ref_cnt[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // shadow shift register: stale or extra bits show up in the expectation
  task automatic wr(input logic [31:0] w, input int n);
    logic [13:0] d;
    sr_m = 18'((64'(sr_m) << n) | 64'(w));
    host.send(w, n);
    d = sr_m[17:4];
    if (sr_m[3:0] == 4'h0) exp_cfg.frac_mode = d[10];
    if (sr_m[3:0] == 4'h1) r1 = d;
    if (sr_m[3:0] == 4'h3) exp_cfg.int_div = d[7:0];
    if (sr_m[3:0] == 4'h3) exp_cfg.frac_div[5:0] = d[13:8];
    if (sr_m[3:0] == 4'h4) exp_cfg.frac_div[19:6] = d;
    if (sr_m[3:0] == 4'h5) r5 = d;
    if (sr_m[3:0] == 4'h5) exp_cfg.ref_div2 = d[2];
    if (sr_m[3:0] == 4'hE) r14 = d;
  endtask

  task automatic chk_syn;
    chk_val(32'(cfg), 32'(exp_cfg));
    chk_pin(div_ok, exp_cfg.int_div >= 8'h40);
  endtask

  task automatic chk_lock;
    for (int l = 0; l < 2; l++)
    begin
      pll_locked_i <= l[0];
      repeat (4) @(posedge clk_sys_i);
      chk_pin(lock_oe, r5[5] & (r1[12] | !l[0]));
      chk_pin(lock_o, r5[5] & r1[12] & l[0]);
      chk_pin(lock_pu, r5[5] & !r1[12] & r5[9]);
    end
  endtask

  // whole periods only, so the rise count is exact
  task automatic chk_ref;
    int rises;
    logic prev;
    rises = 0;
    prev = ref_out;
    repeat (128)
    begin
      @(posedge clk_sys_i);
      if (ref_out && !prev) rises++;
      prev = ref_out;
    end
    chk_val(32'(rises), !r14[9] ? 32'h0 : r14[10] ? 32'h8 : 32'h10);
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_errors++;
    give_verdict;
  end

  initial
  begin
    rst_i = 1'b1;
    pll_locked_i = 1'b0;
    ref_cnt = 3'h0;
    ref_clk_i = 1'b0;
    n_errors = 0;
    n_checks = 0;
    sr_m = 18'h0;
    exp_cfg = '{frac_mode: 1'b1, ref_div2: 1'b1, int_div: 8'h79, frac_div: 20'hD9980};
    r1 = 14'h119A;
    r5 = 14'h00A4;
    r14 = 14'h033B;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk_syn;
    for (int a = 0; a < 16; a++) wr({rec[a], 4'(a)}, 18);
    chk_syn;
    chk_lock;
    chk_ref;
    wr({14'h1A78, 4'h3}, 18);
    wr({14'h2666, 4'h4}, 18);
    chk_syn;
    foreach (div_tbl[i])
    begin
      wr({6'h00, div_tbl[i], 4'h3}, 18);
      chk_syn;
    end
    // ignored pulses, then an address-only word
    host.stray(5);
    wr(32'h3, 4);
    chk_syn;
    wr({4'hF, 14'h2A55, 4'h4}, 22);
    chk_syn;
    wr({14'h1340, 4'h0}, 18);
    wr({14'h00A0, 4'h5}, 18);
    chk_syn;
    // undecoded word with the mode bit set must not reach the mode field
    wr({rec[13], 4'hD}, 18);
    chk_syn;
    foreach (lk1[i])
    begin
      wr({lk1[i], 4'h1}, 18);
      wr({lk5[i], 4'h5}, 18);
      chk_lock;
    end
    foreach (ck_tbl[i])
    begin
      wr({ck_tbl[i], 4'hE}, 18);
      chk_ref;
    end
    give_verdict;
  end
endmodule
